// ---- design/rtc_cal_defines.svh ----
// Register offsets, field positions and reset values of the calendar block
`ifndef RTC_CAL_DEFINES_SVH
`define RTC_CAL_DEFINES_SVH

// Register byte addresses
`define ADDR_CALENDAR_VALUE  32'h400E146C
`define ADDR_TIME_ALARM      32'h400E1470
`define ADDR_CALENDAR_ALARM  32'h400E1474
`define ADDR_CLOCK_STATUS    32'h400E1478
`define ADDR_STATUS_CLEAR    32'h400E147C

// Calendar value fields
`define CAL_HUNDRED_YEAR_FIELD             6:0
`define CAL_YEAR             15:8
`define CAL_MONTH            20:16
`define CAL_DAY              23:21
`define CAL_DATE             29:24
`define CAL_MASK             32'h3FFFFF7F
`define CAL_RESET            32'h01210020

// Time alarm fields
`define TAL_SEC              6:0
`define TAL_SEC_EN           7
`define TAL_MIN              14:8
`define TAL_MIN_EN           15
`define TAL_HOUR             21:16
`define TAL_HALF_DAY         22
`define TAL_HOUR_EN          23
`define TAL_MASK             32'h00FFFFFF
`define TAL_RESET            32'h00000000

// Calendar alarm fields
`define CAL_AL_MONTH         20:16
`define CAL_AL_MONTH_EN      23
`define CAL_AL_DATE          29:24
`define CAL_AL_DATE_EN       31
`define CAL_AL_MASK          32'hBF9F0000
`define CAL_AL_RESET         32'h00000000

// Status flags, bit 0 upward
`define STATUS_WIDTH         6
`define STATUS_RESET         6'h00

`endif

// ---- design/rtc_cal_pkg.sv ----
// Types shared by the calendar, alarm and status block
package rtc_cal_pkg;

  typedef struct packed {
    logic       half_day_indicator;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } time_value_t;

  typedef enum logic [1:0] {
    TEV_MINUTE   = 2'h0,
    TEV_HOUR     = 2'h1,
    TEV_MIDNIGHT = 2'h2,
    TEV_NOON     = 2'h3
  } time_event_select_t;

  typedef enum logic [1:0] {
    CEV_WEEK  = 2'h0,
    CEV_MONTH = 2'h1,
    CEV_YEAR  = 2'h2
  } calendar_event_select_t;

  // Bit order matches the clock status register
  typedef struct packed {
    logic counter_corruption_flag;
    logic calendar_event_flag;
    logic time_event_flag;
    logic one_hz_event;
    logic alarm;
    logic update_grant_flag;
  } status_flags_t;

  typedef struct packed {
    logic [31:0]   calendar;
    logic [31:0]   time_alarm;
    logic [31:0]   calendar_alarm;
    status_flags_t flags;
    time_value_t   prev_time;
    logic          prev_valid;
    logic          prev_match;
    logic          ack;
    logic [31:0]   rdata;
  } state_t;

endpackage

// ---- design/rtc_calendar_alarm_status.sv ----
// Calendar fields, alarm compare and status flags behind a Wishbone slave
`timescale 1ns/10ps
`include "rtc_cal_defines.svh"

// What this block does
// - Century writes accept BCD 19-20 Gregorian or 13-14 Persian; a year 99 roll steps it one past.
// - Year within century holds BCD 00 to 99.
// - Month holds BCD 01 to 12.
// - Day of week holds 1 to 7; it never steers date advance.
// - Day of month holds BCD 01 to 31.
// - Each BCD field keeps units low, tens in the bits above.
// - Calendar bits without a field read zero.
// - Alarm registers ignore writes while write protect is set.
// - Seconds join the match only when their enable is one.
// - Minutes join the match only when their enable is one.
// - Hour and half-day join the match only when enabled.
// - Month joins the match only when its enable is one.
// - Date joins the match only when its enable is one.
// - Update grant reads 0 while free running, 1 once writable.
// - Alarm flag sets when a match begins and holds until cleared.
// - One-second flag sets on a second event and holds until cleared.
// - Time event flag sets on the selected time event, holds.
// - Calendar event flag sets on the selected calendar event, holds.
// - Corruption flag sets while counters hold invalid or non-BCD values.
// - Writing one to a status clear bit clears that flag.
// - Update request stops counting; writes only after the grant.
module rtc_calendar_alarm_status (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [31:0]                     wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  // Time counters and tick
  input  wire rtc_cal_pkg::time_value_t        time_i,
  input  wire logic                            one_hz_event_i,
  // Control from the mode and control registers
  input  wire logic                            update_time_req_i,
  input  wire logic                            update_cal_req_i,
  input  wire logic                            twelve_hour_mode_i,
  input  wire logic                            persian_mode_i,
  input  wire logic                            write_protect_enable_i,
  input  wire rtc_cal_pkg::time_event_select_t time_event_select_i,
  input  wire rtc_cal_pkg::calendar_event_select_t
                                               calendar_event_select_i,
  // State towards interrupt logic and readers
  output rtc_cal_pkg::status_flags_t           status_flags_o,
  output logic      [31:0]                     calendar_value_o,
  output logic                                 alarm_match_o
);

  rtc_cal_pkg::state_t state_reg;
  rtc_cal_pkg::state_t state_next;

  // BCD increment of one byte; caller handles wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Both digits decimal and value inside [lo, hi]
  function automatic logic bcd_ok(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  // Gregorian leap year; a century year is leap only for the 2000s
  function automatic logic leap_year(input logic [7:0] hundred_year_field,
                                     input logic [7:0] year);
    if (year == 8'h00) begin
      leap_year = (hundred_year_field == 8'h20);
    end else if (year[4]) begin
      leap_year = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
    end else begin
      leap_year = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) ||
                  (year[3:0] == 4'h8);
    end
  endfunction

  // Last date of the month in BCD; Persian leap years are not tracked
  function automatic logic [7:0] month_days(input logic [7:0] month,
                                            input logic [7:0] hundred_year_field,
                                            input logic [7:0] year,
                                            input logic       persian);
    if (persian) begin
      if (month <= 8'h06) begin
        month_days = 8'h31;
      end else if (month <= 8'h11) begin
        month_days = 8'h30;
      end else begin
        month_days = 8'h29;
      end
    end else if (month == 8'h02) begin
      month_days = leap_year(hundred_year_field, year) ? 8'h29 : 8'h28;
    end else if ((month == 8'h04) || (month == 8'h06) ||
                 (month == 8'h09) || (month == 8'h11)) begin
      month_days = 8'h30;
    end else begin
      month_days = 8'h31;
    end
  endfunction

  // Whole calendar word inside its documented ranges
  function automatic logic calendar_ok(input logic [31:0] c,
                                       input logic        persian);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = persian ? 8'h13 : 8'h19;
    hi = persian ? 8'h14 : 8'h20;
    calendar_ok = bcd_ok({1'b0, c[`CAL_HUNDRED_YEAR_FIELD]}, lo, hi) &&
                  bcd_ok(c[`CAL_YEAR], 8'h00, 8'h99) &&
                  bcd_ok({3'h0, c[`CAL_MONTH]}, 8'h01, 8'h12) &&
                  (c[`CAL_DAY] >= 3'h1) &&
                  bcd_ok({2'h0, c[`CAL_DATE]}, 8'h01, 8'h31);
  endfunction

  // Byte-lane merge of a Wishbone write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    integer i;
    merge = old;
    for (i = 0; i < 4; i = i + 1) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  endfunction

  logic        access;
  logic        write_now;
  logic [31:0] wval;
  logic [31:0] rd_mux;
  logic        can_write_cal;
  logic        time_ok;
  logic        noon_hour;
  logic        midnight_hour;
  logic        hour_changed;
  logic        min_changed;
  logic        day_roll;
  logic        time_event;
  logic        cal_event;
  logic        match;
  logic        any_enabled;
  logic [7:0]  cur_month;
  logic [7:0]  cur_date;
  logic [7:0]  cur_year;
  logic [7:0]  cur_hundred_year_field;
  logic [7:0]  last_date;
  logic [31:0] adv;
  logic [31:0] clr_word;
  logic [7:0]  hundred_year_field_inc;
  logic [7:0]  month_inc;
  logic [7:0]  date_inc;
  rtc_cal_pkg::status_flags_t set_flags;
  rtc_cal_pkg::status_flags_t clr_flags;

  always_comb begin
    state_next    = state_reg;
    set_flags     = '0;
    clr_flags     = '0;
    adv           = state_reg.calendar;
    clr_word      = 32'h00000000;
    wval          = 32'h00000000;
    rd_mux        = 32'h00000000;
    day_roll      = 1'b0;
    cal_event     = 1'b0;
    time_event    = 1'b0;

    access    = wb_cyc_i && wb_stb_i;
    // The write lands on the edge where the master sees ack high
    write_now = access && wb_we_i && state_reg.ack;

    // Classic single cycle: ack one clock after the strobe, then drop
    state_next.ack = access && !state_reg.ack;

    case (wb_adr_i)
      `ADDR_CALENDAR_VALUE:  rd_mux = state_reg.calendar & `CAL_MASK;
      `ADDR_TIME_ALARM:      rd_mux = state_reg.time_alarm;
      `ADDR_CALENDAR_ALARM:  rd_mux = state_reg.calendar_alarm;
      `ADDR_CLOCK_STATUS:    rd_mux = {26'h0000000, state_reg.flags};
      default:               rd_mux = 32'h00000000;
    endcase
    if (state_next.ack) begin
      state_next.rdata = rd_mux;
    end

    // Counters may be changed only once the grant is up
    can_write_cal = update_cal_req_i && state_reg.flags.update_grant_flag;

    if (write_now) begin
      case (wb_adr_i)
        `ADDR_CALENDAR_VALUE: begin
          wval = merge(state_reg.calendar, wb_dat_i, wb_sel_i) & `CAL_MASK;
          // Out-of-range words are dropped whole
          if (can_write_cal && calendar_ok(wval, persian_mode_i)) begin
            state_next.calendar = wval;
          end
        end
        `ADDR_TIME_ALARM: begin
          if (!write_protect_enable_i) begin
            state_next.time_alarm =
              merge(state_reg.time_alarm, wb_dat_i, wb_sel_i) & `TAL_MASK;
          end
        end
        `ADDR_CALENDAR_ALARM: begin
          if (!write_protect_enable_i) begin
            state_next.calendar_alarm =
              merge(state_reg.calendar_alarm, wb_dat_i, wb_sel_i) &
              `CAL_AL_MASK;
          end
        end
        `ADDR_STATUS_CLEAR: begin
          clr_word  = merge(32'h00000000, wb_dat_i, wb_sel_i);
          clr_flags = clr_word[`STATUS_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // Edges of the time counters
    min_changed  = state_reg.prev_valid && !update_time_req_i &&
                   (time_i.min != state_reg.prev_time.min);
    hour_changed = state_reg.prev_valid && !update_time_req_i &&
                   (time_i.hour != state_reg.prev_time.hour);
    midnight_hour = twelve_hour_mode_i ?
                    (time_i.hour == 6'h12) && !time_i.half_day_indicator :
                    (time_i.hour == 6'h00);
    noon_hour     = twelve_hour_mode_i ?
                    (time_i.hour == 6'h12) && time_i.half_day_indicator :
                    (time_i.hour == 6'h12);

    case (time_event_select_i)
      rtc_cal_pkg::TEV_MINUTE:   time_event = min_changed;
      rtc_cal_pkg::TEV_HOUR:     time_event = hour_changed;
      rtc_cal_pkg::TEV_MIDNIGHT: time_event = hour_changed && midnight_hour;
      rtc_cal_pkg::TEV_NOON:     time_event = hour_changed && noon_hour;
      default:                   time_event = 1'b0;
    endcase

    // Day rollover advances the calendar unless it is held for update
    day_roll  = hour_changed && midnight_hour && !update_cal_req_i;
    cur_hundred_year_field  = {1'b0, state_reg.calendar[`CAL_HUNDRED_YEAR_FIELD]};
    cur_year  = state_reg.calendar[`CAL_YEAR];
    cur_month = {3'h0, state_reg.calendar[`CAL_MONTH]};
    cur_date  = {2'h0, state_reg.calendar[`CAL_DATE]};
    last_date = month_days(cur_month, cur_hundred_year_field, cur_year, persian_mode_i);
    hundred_year_field_inc  = bcd_inc(cur_hundred_year_field);
    month_inc = bcd_inc(cur_month);
    date_inc  = bcd_inc(cur_date);
    // Weekday steps on its own, never feeding the date length
    adv[`CAL_DAY] = (state_reg.calendar[`CAL_DAY] == 3'h7) ? 3'h1 :
                    state_reg.calendar[`CAL_DAY] + 3'h1;
    if (cur_date >= last_date) begin
      adv[`CAL_DATE] = 6'h01;
      if (cur_month >= 8'h12) begin
        adv[`CAL_MONTH] = 5'h01;
        if (cur_year == 8'h99) begin
          adv[`CAL_YEAR] = 8'h00;
          adv[`CAL_HUNDRED_YEAR_FIELD] = hundred_year_field_inc[6:0];
        end else begin
          adv[`CAL_YEAR] = bcd_inc(cur_year);
        end
      end else begin
        adv[`CAL_MONTH] = month_inc[4:0];
      end
    end else begin
      adv[`CAL_DATE] = date_inc[5:0];
    end
    // A calendar write needs the update request, so it never meets a roll
    if (day_roll) begin
      state_next.calendar = adv;
    end

    // Day 1 stands for the first weekday
    case (calendar_event_select_i)
      rtc_cal_pkg::CEV_WEEK:  cal_event = day_roll && (adv[`CAL_DAY] == 3'h1);
      rtc_cal_pkg::CEV_MONTH: cal_event = day_roll &&
                                          (adv[`CAL_DATE] == 6'h01);
      rtc_cal_pkg::CEV_YEAR:  cal_event = day_roll &&
                                          (adv[`CAL_DATE] == 6'h01) &&
                                          (adv[`CAL_MONTH] == 5'h01);
      default:                cal_event = 1'b0;
    endcase

    // Alarm compare, each field gated by its enable
    any_enabled = state_reg.time_alarm[`TAL_SEC_EN] ||
                  state_reg.time_alarm[`TAL_MIN_EN] ||
                  state_reg.time_alarm[`TAL_HOUR_EN] ||
                  state_reg.calendar_alarm[`CAL_AL_MONTH_EN] ||
                  state_reg.calendar_alarm[`CAL_AL_DATE_EN];
    match = any_enabled &&
      (!state_reg.time_alarm[`TAL_SEC_EN] ||
       (state_reg.time_alarm[`TAL_SEC] == time_i.sec)) &&
      (!state_reg.time_alarm[`TAL_MIN_EN] ||
       (state_reg.time_alarm[`TAL_MIN] == time_i.min)) &&
      (!state_reg.time_alarm[`TAL_HOUR_EN] ||
       ((state_reg.time_alarm[`TAL_HOUR] == time_i.hour) &&
        (state_reg.time_alarm[`TAL_HALF_DAY] ==
         time_i.half_day_indicator))) &&
      (!state_reg.calendar_alarm[`CAL_AL_MONTH_EN] ||
       (state_reg.calendar_alarm[`CAL_AL_MONTH] ==
        state_reg.calendar[`CAL_MONTH])) &&
      (!state_reg.calendar_alarm[`CAL_AL_DATE_EN] ||
       (state_reg.calendar_alarm[`CAL_AL_DATE] ==
        state_reg.calendar[`CAL_DATE]));
    state_next.prev_match = match;

    // Counter sanity; 12-hour mode runs 1..12, 24-hour 0..23
    time_ok = bcd_ok({1'b0, time_i.sec}, 8'h00, 8'h59) &&
              bcd_ok({1'b0, time_i.min}, 8'h00, 8'h59) &&
              (twelve_hour_mode_i ?
               bcd_ok({2'h0, time_i.hour}, 8'h01, 8'h12) :
               bcd_ok({2'h0, time_i.hour}, 8'h00, 8'h23));

    // Set sources; each beats a clear landing in the same cycle
    set_flags.update_grant_flag  = (update_time_req_i || update_cal_req_i) &&
                                   one_hz_event_i;
    set_flags.alarm              = match && !state_reg.prev_match;
    set_flags.one_hz_event       = one_hz_event_i;
    set_flags.time_event_flag    = time_event;
    set_flags.calendar_event_flag = cal_event;
    set_flags.counter_corruption_flag =
      !time_ok || !calendar_ok(state_reg.calendar, persian_mode_i);

    // Grant falls as soon as both requests are gone
    if (!update_time_req_i && !update_cal_req_i) begin
      clr_flags.update_grant_flag = 1'b1;
    end

    state_next.flags = set_flags | (state_reg.flags & ~clr_flags);

    state_next.prev_time  = time_i;
    state_next.prev_valid = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.calendar       <= `CAL_RESET;
      state_reg.time_alarm     <= `TAL_RESET;
      state_reg.calendar_alarm <= `CAL_AL_RESET;
      state_reg.flags          <= `STATUS_RESET;
      state_reg.prev_time      <= '0;
      state_reg.prev_valid     <= 1'b0;
      state_reg.prev_match     <= 1'b0;
      state_reg.ack            <= 1'b0;
      state_reg.rdata          <= 32'h00000000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o         = state_reg.ack;
  assign wb_dat_o         = state_reg.rdata;
  assign status_flags_o   = state_reg.flags;
  assign calendar_value_o = state_reg.calendar;
  assign alarm_match_o    = state_reg.prev_match;

endmodule // rtc_calendar_alarm_status

// ---- verif/rtc_cal_asserts.sv ----
// Bus timing and status flag checks for the calendar block
`timescale 1ns/10ps
`include "rtc_cal_defines.svh"
module rtc_cal_asserts (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone side
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [31:0]                wb_adr_i,
  input  wire logic [31:0]                wb_dat_o,
  input  wire logic                       wb_ack_o,
  // Events and flags
  input  wire logic                       one_hz_event_i,
  input  wire logic                       update_time_req_i,
  input  wire logic                       update_cal_req_i,
  input  wire rtc_cal_pkg::status_flags_t status_flags_o,
  input  wire logic [31:0]                calendar_value_o,
  input  wire logic                       alarm_match_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Any write to the clear address may drop a flag, so hold checks skip it
  wire clr_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
               && wb_adr_i == `ADDR_STATUS_CLEAR;
  wire req_any = update_time_req_i || update_cal_req_i;

  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
  endsequence

  AST_ACK_NEXT: assert property (req_s |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_SEC_SET: assert property (
    one_hz_event_i |=> status_flags_o.one_hz_event)
    else $error("one second flag not set");
  AST_SEC_HOLD: assert property (
    status_flags_o.one_hz_event && !clr_w |=> status_flags_o.one_hz_event)
    else $error("one second flag dropped");
  AST_GRANT_SET: assert property (one_hz_event_i && req_any
    |=> status_flags_o.update_grant_flag) else $error("grant not set");
  AST_GRANT_FREE: assert property (!req_any
    |=> !status_flags_o.update_grant_flag) else $error("grant while free");
  AST_ALARM_SET: assert property ($rose(alarm_match_o)
    |-> status_flags_o.alarm) else $error("alarm flag not set on match");
  // Read data is captured on the edge that raises ack, so a day roll may follow it
  AST_CAL_READ: assert property (
    rd_s ##0 wb_adr_i == `ADDR_CALENDAR_VALUE
    |-> wb_dat_o == ($past(calendar_value_o) & `CAL_MASK))
    else $error("calendar read differs");
  AST_RSV_ZERO: assert property (
    (calendar_value_o & ~`CAL_MASK) == 32'h0)
    else $error("calendar reserved bit set");
  AST_UNMAPPED: assert property (
    rd_s ##0 wb_adr_i > `ADDR_CLOCK_STATUS |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // rtc_cal_asserts

bind rtc_calendar_alarm_status rtc_cal_asserts chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .one_hz_event_i(one_hz_event_i),
  .update_time_req_i(update_time_req_i),
  .update_cal_req_i(update_cal_req_i), .status_flags_o(status_flags_o),
  .calendar_value_o(calendar_value_o), .alarm_match_o(alarm_match_o));

// ---- verif/rtc_calendar_alarm_status_test.sv ----
// Self-checking bench for the calendar, alarm and status block
`timescale 1ns/10ps
`include "rtc_cal_defines.svh"
module rtc_calendar_alarm_status_test;
  logic                       clk_i, rst_i, cyc, stb, we;
  logic                       ack, match_o, hz, utr, ucr, wp, pm;
  logic [31:0]                adr, wdat, dat_o, cal_o, q;
  logic [3:0]                 sel;
  rtc_cal_pkg::time_value_t   tm;
  rtc_cal_pkg::status_flags_t flags;
  rtc_cal_pkg::time_event_select_t tsel;
  int                         num_errors, checked;

  rtc_calendar_alarm_status uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .time_i(tm), .one_hz_event_i(hz),
    .update_time_req_i(utr), .update_cal_req_i(ucr),
    .twelve_hour_mode_i(1'b0), .persian_mode_i(pm),
    .write_protect_enable_i(wp),
    .time_event_select_i(tsel),
    .calendar_event_select_i(rtc_cal_pkg::CEV_WEEK),
    .status_flags_o(flags), .calendar_value_o(cal_o),
    .alarm_match_o(match_o));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; released only at the edge where ack is seen
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    // Ack is due at the second edge; only the watchdog ends a hang
    chk(n, 32'h2);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_reset;
    rd(`ADDR_CALENDAR_VALUE, `CAL_RESET);
    rd(`ADDR_TIME_ALARM, 32'h0);
    rd(`ADDR_CALENDAR_ALARM, 32'h0);
    rd(`ADDR_CLOCK_STATUS, 32'h0);
    rd(`ADDR_STATUS_CLEAR, 32'h0);
    rd(32'h400E1480, 32'h0);
  endtask

  task automatic t_protect;
    wp <= 1'b1;
    wb(1'b1, `ADDR_TIME_ALARM, 32'h0000B085);
    rd(`ADDR_TIME_ALARM, 32'h0);
    wb(1'b1, `ADDR_CALENDAR_ALARM, 32'h82810000);
    rd(`ADDR_CALENDAR_ALARM, 32'h0);
    wp <= 1'b0;
    wb(1'b1, `ADDR_TIME_ALARM, 32'hFF00B085);
    rd(`ADDR_TIME_ALARM, 32'h0000B085);
  endtask

  task automatic t_time_alarm;
    tm.min <= 7'h30;
    tick(3);
    rd(`ADDR_CLOCK_STATUS, 32'h08);
    chk(match_o, 1'b0);
    tm.sec <= 7'h05;
    tick(3);
    chk(match_o, 1'b1);
    rd(`ADDR_CLOCK_STATUS, 32'h0A);
    wb(1'b1, `ADDR_STATUS_CLEAR, 32'h0000000A);
    rd(`ADDR_CLOCK_STATUS, 32'h0);
    // Disable, change, re-enable the minute field
    wb(1'b1, `ADDR_TIME_ALARM, 32'h00003085);
    wb(1'b1, `ADDR_TIME_ALARM, 32'h00003185);
    wb(1'b1, `ADDR_TIME_ALARM, 32'h0000B185);
    // Match output trails the register write by one edge
    tick(2);
    chk(match_o, 1'b0);
    tm.min <= 7'h31;
    tick(3);
    rd(`ADDR_CLOCK_STATUS, 32'h0A);
    wb(1'b1, `ADDR_TIME_ALARM, 32'h0);
    wb(1'b1, `ADDR_STATUS_CLEAR, 32'h3F);
    chk(match_o, 1'b0);
  endtask

  task automatic t_cal_update;
    wb(1'b1, `ADDR_CALENDAR_ALARM, 32'h82810000);
    chk(match_o, 1'b0);
    ucr <= 1'b1;
    wb(1'b1, `ADDR_CALENDAR_VALUE, 32'h02212020);
    rd(`ADDR_CALENDAR_VALUE, `CAL_RESET);
    @(posedge clk_i);
    hz <= 1'b1;
    @(posedge clk_i);
    hz <= 1'b0;
    tick(2);
    rd(`ADDR_CLOCK_STATUS, 32'h05);
    wb(1'b1, `ADDR_CALENDAR_VALUE, 32'h02332020);
    rd(`ADDR_CALENDAR_VALUE, `CAL_RESET);
    wb(1'b1, `ADDR_CALENDAR_VALUE, 32'h02212014);
    rd(`ADDR_CALENDAR_VALUE, `CAL_RESET);
    wb(1'b1, `ADDR_CALENDAR_VALUE, 32'h02212020);
    rd(`ADDR_CALENDAR_VALUE, 32'h02212020);
    chk(cal_o, 32'h02212020);
    tick(2);
    rd(`ADDR_CLOCK_STATUS, 32'h07);
    ucr <= 1'b0;
    tick(2);
    rd(`ADDR_CLOCK_STATUS, 32'h06);
  endtask

  task automatic t_corrupt;
    wb(1'b1, `ADDR_STATUS_CLEAR, 32'h3F);
    tm.sec <= 7'h5A;
    tick(1);
    tm.sec <= 7'h05;
    tick(3);
    rd(`ADDR_CLOCK_STATUS, 32'h20);
    wb(1'b1, `ADDR_STATUS_CLEAR, 32'h0);
    rd(`ADDR_CLOCK_STATUS, 32'h20);
    wb(1'b1, `ADDR_STATUS_CLEAR, 32'h20);
    rd(`ADDR_CLOCK_STATUS, 32'h0);
  endtask

  // Midnight roll steps date and weekday; Persian century then accepted
  task automatic t_modes;
    tsel <= rtc_cal_pkg::TEV_MIDNIGHT;
    tm.hour <= 6'h01;
    tick(3);
    tm.hour <= 6'h00;
    tick(3);
    rd(`ADDR_CLOCK_STATUS, 32'h08);
    chk(flags, 32'h08);
    chk(cal_o, 32'h03412020);
    pm <= 1'b1;
    ucr <= 1'b1;
    @(posedge clk_i);
    hz <= 1'b1;
    @(posedge clk_i);
    hz <= 1'b0;
    wb(1'b1, `ADDR_CALENDAR_VALUE, 32'h03412014);
    rd(`ADDR_CALENDAR_VALUE, 32'h03412014);
    rd(`ADDR_CLOCK_STATUS, 32'h2D);
    ucr <= 1'b0;
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Whole run is under two hundred cycles; this span leaves a wide margin
  initial begin
    #40000;
    num_errors++;
    test_done();
  end

  initial begin
    {cyc, stb, we, hz, utr, ucr, wp, pm} = '0;
    tsel = rtc_cal_pkg::TEV_MINUTE;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'hF;
    tm = '0;
    num_errors = 0;
    checked = 0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_protect();
    t_time_alarm();
    t_cal_update();
    t_corrupt();
    t_modes();
    test_done();
  end
endmodule // rtc_calendar_alarm_status_test
